// [esc_pkg.sv]
// constants, register map and drive encodings for the edge shaping control block
// assumes one carrier clock domain; registers are reached by a plain byte access port
package esc_pkg;

   // pattern window length in carrier cycles
   localparam int PATTERN_LEN = 14;
   localparam int NUM_REGS    = 10;

   // register offsets
   localparam logic [7:0] ADDR_AUX_MODULATION   = 8'h28;
   localparam logic [7:0] ADDR_SHAPING_CONFIG   = 8'h2E;
   localparam logic [7:0] ADDR_SHAPING_CONFIG2  = 8'h2F;
   localparam logic [7:0] ADDR_SWITCH_FALLING   = 8'h30;
   localparam logic [7:0] ADDR_SWITCH_RISING    = 8'h31;
   localparam logic [7:0] ADDR_OVERSHOOT_LO     = 8'h34;
   localparam logic [7:0] ADDR_OVERSHOOT_HI     = 8'h35;
   localparam logic [7:0] ADDR_UNDERSHOOT_LO    = 8'h36;
   localparam logic [7:0] ADDR_UNDERSHOOT_HI    = 8'h37;
   localparam logic [7:0] ADDR_TX_DRIVER        = 8'h38;
   localparam logic [7:0] ADDR_STATUS           = 8'h3A;

   // register table, index order used by the register file
   localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
      ADDR_AUX_MODULATION, ADDR_SHAPING_CONFIG, ADDR_SHAPING_CONFIG2,
      ADDR_SWITCH_FALLING, ADDR_SWITCH_RISING, ADDR_OVERSHOOT_LO,
      ADDR_OVERSHOOT_HI, ADDR_UNDERSHOOT_LO, ADDR_UNDERSHOOT_HI, ADDR_TX_DRIVER};

   // register indices
   localparam int IDX_AUX  = 0;
   localparam int IDX_CFG  = 1;
   localparam int IDX_CFG2 = 2;
   localparam int IDX_TFAL = 3;
   localparam int IDX_TRIS = 4;
   localparam int IDX_OVLO = 5;
   localparam int IDX_OVHI = 6;
   localparam int IDX_UNLO = 7;
   localparam int IDX_UNHI = 8;
   localparam int IDX_TXDR = 9;

   // value after reset of every writable register
   localparam logic [7:0] REG_RESET = 8'h00;

   // field positions
   localparam int AUX_SHAPE_EN_BIT  = 7;
   localparam int CFG_SHAPE_EN_BIT  = 3;
   localparam int CFG2_SYM_BIT      = 5;
   localparam int CFG2_SINK_BIT     = 4;
   localparam int CFG2_FILT_LSB     = 0;
   localparam int PAT_HI_BITS       = 6;
   localparam int PAT_SEL_LSB       = 6;
   localparam int TXDR_DEPTH_LSB    = 4;
   localparam int TXDR_LEGACY_BIT   = 0;

   // drive select codes
   localparam logic [1:0] SEL_DRIVER_RAIL = 2'h0;
   localparam logic [1:0] SEL_MOD_RAIL    = 2'h1;
   localparam logic [1:0] SEL_STOPPED     = 2'h2;

   typedef enum logic [1:0] {
      ESC_DRV_DRIVER_RAIL,
      ESC_DRV_MOD_RAIL,
      ESC_DRV_STOPPED
   } esc_drive_e;

endpackage

// [esc_rail_ramp.sv]
// slew limiter for the modulation rail level code
// assumes target and settings come from the register file in the same clock domain
`timescale 1ns/1ns

module esc_rail_ramp #(
   parameter int LEVEL_W = 4
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               enable,
   input  wire logic               symmetric,
   input  wire logic [3:0]         filter_speed,
   input  wire logic [LEVEL_W-1:0] target,
   output logic      [LEVEL_W-1:0] level
);

   logic [4:0] tick_cnt;
   logic [4:0] next_tick_cnt;
   logic [LEVEL_W-1:0] next_level;
   wire        going_up   = target > level;
   wire        going_down = target < level;
   // larger code, longer interval between steps
   wire        step_due   = tick_cnt >= {1'b0, filter_speed};
   // asymmetric shape lets the modulation edge drop at once
   wire        fast_edge  = going_up && !symmetric;

   always_comb begin
      next_tick_cnt = tick_cnt + 5'h1;
      next_level    = level;
      if (!enable || fast_edge) begin
         next_level    = target;
         next_tick_cnt = 5'h0;
      end else if (going_up || going_down) begin
         if (step_due) begin
            next_tick_cnt = 5'h0;
            next_level    = going_up ? level + 1'b1 : level - 1'b1;
         end
      end else begin
         next_tick_cnt = 5'h0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 5'h0;
         level    <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
         level    <= next_level;
      end
   end

endmodule // esc_rail_ramp

// [esc_edge_shaping.sv]
// transmitter edge shaping control: overshoot/undershoot patterns, clamp timers,
// modulation rail slew and its register file
// assumes modulated is synchronous to clk, the carrier clock
`timescale 1ns/1ns

module esc_edge_shaping #(
   parameter int PAT_LEN = esc_pkg::PATTERN_LEN
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              modulated,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   output esc_pkg::esc_drive_e    drive_source,
   output logic      [3:0]        modulation_rail_level,
   output logic                   clamp_switch_active,
   output logic                   strong_sink_active,
   output logic                   pattern_active
);

   localparam int IDX_W = $clog2(PAT_LEN);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(PAT_LEN - 1);

   // register file
   logic [7:0] regs [esc_pkg::NUM_REGS];
   wire  [esc_pkg::NUM_REGS-1:0] reg_hit;
   wire  status_hit = reg_addr == esc_pkg::ADDR_STATUS;

   genvar gi;
   generate
      for (gi = 0; gi < esc_pkg::NUM_REGS; gi++) begin : g_reg
         assign reg_hit[gi] = reg_addr == esc_pkg::REG_ADDR[gi];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               regs[gi] <= esc_pkg::REG_RESET;
            end else if (reg_wr && reg_hit[gi]) begin
               regs[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // field decode
   wire [PAT_LEN-1:0] overshoot_bit_pattern =
      {regs[esc_pkg::IDX_OVHI][esc_pkg::PAT_HI_BITS-1:0], regs[esc_pkg::IDX_OVLO]};
   wire [1:0] overshoot_drive_select =
      regs[esc_pkg::IDX_OVHI][esc_pkg::PAT_SEL_LSB +: 2];
   wire [PAT_LEN-1:0] undershoot_bit_pattern =
      {regs[esc_pkg::IDX_UNHI][esc_pkg::PAT_HI_BITS-1:0], regs[esc_pkg::IDX_UNLO]};
   wire [1:0] undershoot_drive_select =
      regs[esc_pkg::IDX_UNHI][esc_pkg::PAT_SEL_LSB +: 2];
   wire [3:0] modulation_depth_code =
      regs[esc_pkg::IDX_TXDR][esc_pkg::TXDR_DEPTH_LSB +: 4];
   // kept for readback only; pattern logic never looks at it
   wire       legacy_regulator_select =
      regs[esc_pkg::IDX_TXDR][esc_pkg::TXDR_LEGACY_BIT];
   wire       symmetric_shape_select =
      regs[esc_pkg::IDX_CFG2][esc_pkg::CFG2_SYM_BIT];
   wire       modulation_sink_strong =
      regs[esc_pkg::IDX_CFG2][esc_pkg::CFG2_SINK_BIT];
   wire [3:0] regulator_filter_speed =
      regs[esc_pkg::IDX_CFG2][esc_pkg::CFG2_FILT_LSB +: 4];
   wire [7:0] switch_timer_falling = regs[esc_pkg::IDX_TFAL];
   wire [7:0] switch_timer_rising  = regs[esc_pkg::IDX_TRIS];
   // both enables must be set for the clamp timers, strong sink and rail slew to act; the pattern sequencer runs without them
   wire       edge_shaping_on =
      regs[esc_pkg::IDX_AUX][esc_pkg::AUX_SHAPE_EN_BIT] &&
      regs[esc_pkg::IDX_CFG][esc_pkg::CFG_SHAPE_EN_BIT];

   // transition detection
   logic mod_q;
   wire  mod_start = modulated && !mod_q;
   wire  mod_end   = !modulated && mod_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mod_q <= 1'b0;
      end else begin
         mod_q <= modulated;
      end
   end

   // pattern sequencer
   logic [PAT_LEN-1:0] seq_pat;
   logic [PAT_LEN-1:0] next_seq_pat;
   logic [1:0]         seq_sel;
   logic [1:0]         next_seq_sel;
   logic [IDX_W-1:0]   seq_idx;
   logic [IDX_W-1:0]   next_seq_idx;
   logic               seq_active;
   logic               next_seq_active;

   always_comb begin
      next_seq_pat    = seq_pat;
      next_seq_sel    = seq_sel;
      next_seq_idx    = seq_idx;
      next_seq_active = seq_active;
      if (mod_end) begin
         next_seq_pat    = overshoot_bit_pattern;
         next_seq_sel    = overshoot_drive_select;
         next_seq_idx    = '0;
         next_seq_active = 1'b1;
      end else if (mod_start) begin
         next_seq_pat    = undershoot_bit_pattern;
         next_seq_sel    = undershoot_drive_select;
         next_seq_idx    = '0;
         next_seq_active = 1'b1;
      end else if (seq_active) begin
         if (seq_idx == LAST_IDX) begin
            next_seq_active = 1'b0;
         end else begin
            next_seq_idx = seq_idx + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_pat    <= '0;
         seq_sel    <= esc_pkg::SEL_DRIVER_RAIL;
         seq_idx    <= '0;
         seq_active <= 1'b0;
      end else begin
         seq_pat    <= next_seq_pat;
         seq_sel    <= next_seq_sel;
         seq_idx    <= next_seq_idx;
         seq_active <= next_seq_active;
      end
   end

   // drive choice for the coming cycle
   wire normal_is_mod = modulated;
   wire pattern_bit   = next_seq_active && next_seq_pat[next_seq_idx];
   esc_pkg::esc_drive_e normal_drive;
   esc_pkg::esc_drive_e next_drive;

   assign normal_drive = normal_is_mod ? esc_pkg::ESC_DRV_MOD_RAIL
                                       : esc_pkg::ESC_DRV_DRIVER_RAIL;

   always_comb begin
      next_drive = normal_drive;
      if (pattern_bit) begin
         case (next_seq_sel)
            esc_pkg::SEL_DRIVER_RAIL: begin
               next_drive = esc_pkg::ESC_DRV_DRIVER_RAIL;
            end
            esc_pkg::SEL_MOD_RAIL: begin
               next_drive = esc_pkg::ESC_DRV_MOD_RAIL;
            end
            esc_pkg::SEL_STOPPED: begin
               next_drive = esc_pkg::ESC_DRV_STOPPED;
            end
            default: begin
               next_drive = normal_drive;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_source   <= esc_pkg::ESC_DRV_DRIVER_RAIL;
         pattern_active <= 1'b0;
      end else begin
         drive_source   <= next_drive;
         pattern_active <= next_seq_active;
      end
   end

   // clamp switching timers between the two supply rails
   logic [7:0] clamp_cnt;
   logic [7:0] next_clamp_cnt;

   always_comb begin
      next_clamp_cnt = clamp_cnt;
      if (!edge_shaping_on) begin
         next_clamp_cnt = 8'h00;
      end else if (mod_start) begin
         next_clamp_cnt = switch_timer_falling;
      end else if (mod_end) begin
         next_clamp_cnt = switch_timer_rising;
      end else if (clamp_cnt != 8'h00) begin
         next_clamp_cnt = clamp_cnt - 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clamp_cnt           <= 8'h00;
         clamp_switch_active <= 1'b0;
         strong_sink_active  <= 1'b0;
      end else begin
         clamp_cnt           <= next_clamp_cnt;
         clamp_switch_active <= next_clamp_cnt != 8'h00;
         strong_sink_active  <= edge_shaping_on && modulation_sink_strong && modulated;
      end
   end

   // rail level: depth code while modulated, zero index otherwise
   wire [3:0] rail_target = modulated ? modulation_depth_code : 4'h0;

   esc_rail_ramp #(
      .LEVEL_W      (4)
   ) u_ramp (
      .clk          (clk),
      .rst          (rst),
      .enable       (edge_shaping_on),
      .symmetric    (symmetric_shape_select),
      .filter_speed (regulator_filter_speed),
      .target       (rail_target),
      .level        (modulation_rail_level)
   );

   // readback
   logic [7:0] rd_mux;
   wire  [7:0] status_word = {seq_active, mod_q, clamp_switch_active,
                              edge_shaping_on, 4'(seq_idx)};

   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < esc_pkg::NUM_REGS; i++) begin
         if (reg_hit[i]) begin
            rd_mux = regs[i];
         end
      end
      if (status_hit) begin
         rd_mux = status_word;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

endmodule // esc_edge_shaping

// [esc_edge_shaping_sva.sv]
// assertion checker for the edge shaping control block, bound to its ports
// assumes registers are not written while a pattern window runs
`timescale 1ns/1ns
module esc_edge_shaping_sva #(
   parameter int PAT_LEN = 14
) (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                modulated,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic [7:0]          reg_rdata,
   input wire esc_pkg::esc_drive_e drive_source,
   input wire logic [3:0]          modulation_rail_level,
   input wire logic                clamp_switch_active,
   input wire logic                strong_sink_active,
   input wire logic                pattern_active
);
   logic [7:0]  sh [256];
   logic        mod_q;
   logic [4:0]  cnt;
   // shadow of written registers and cycles since the last transition
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 256; i++) sh[i] <= 8'h00;
         mod_q <= 1'b0;
         cnt   <= 5'h00;
      end else begin
         if (reg_wr) sh[reg_addr] <= reg_wdata;
         mod_q <= modulated;
         if (modulated != mod_q) cnt <= 5'h01;
         else if (cnt != 5'h00 && cnt < 5'h10) cnt <= 5'(cnt + 5'h01);
      end
   end
   wire [13:0] pat  = mod_q ? {sh[8'h37][5:0], sh[8'h36]} : {sh[8'h35][5:0], sh[8'h34]};
   wire [1:0]  sel  = mod_q ? sh[8'h37][7:6] : sh[8'h35][7:6];
   wire        pbit = cnt != 5'h00 && cnt <= 5'(PAT_LEN) && pat[cnt - 5'h01];
   wire [1:0]  exp_drv = (pbit && sel != 2'h3) ? sel : {1'b0, mod_q};
   wire        shon = sh[8'h28][7] && sh[8'h2E][3];

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_trans;
      modulated != mod_q;
   endsequence
   property p_active; s_trans |=> pattern_active [*8]; endproperty
   a_active: assert property (p_active) else $error("window not active");
   property p_drive; 2'(drive_source) == exp_drv; endproperty
   a_drive: assert property (p_drive) else $error("drive source off");
   property p_end; cnt > 5'(PAT_LEN) |-> !pattern_active; endproperty
   a_end: assert property (p_end) else $error("window too long");
   property p_unmap; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_read; reg_rd && !reg_wr && reg_addr == 8'h34 |=> reg_rdata == sh[8'h34];
   endproperty
   a_read: assert property (p_read) else $error("pattern readback off");
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_clamp; shon && !mod_q && modulated && sh[8'h30] != 8'h00 |=> clamp_switch_active;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp not started");
   property p_sink; modulated && shon && sh[8'h2F][4] |=> strong_sink_active; endproperty
   a_sink: assert property (p_sink) else $error("sink not active");
endmodule // esc_edge_shaping_sva

bind esc_edge_shaping esc_edge_shaping_sva #(.PAT_LEN(PAT_LEN)) esc_edge_shaping_sva_i (
   .clk(clk), .rst(rst), .modulated(modulated), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .drive_source(drive_source), .modulation_rail_level(modulation_rail_level),
   .clamp_switch_active(clamp_switch_active), .strong_sink_active(strong_sink_active),
   .pattern_active(pattern_active));

// [esc_driver_model.sv]
// behavioural transmitter driver stage fed by the shaping control
// assumes drive source and rail level are registered on the carrier clock
`timescale 1ns/1ns
module esc_driver_model (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire esc_pkg::esc_drive_e drive_source,
   input  wire logic [3:0]          modulation_rail_level,
   output logic      [4:0]          field_level
);
   // stopped outputs give no field, the modulation rail lowers it by the rail level code
   always_ff @(posedge clk or posedge rst) begin
      if (rst) field_level <= 5'h10;
      else if (drive_source == esc_pkg::ESC_DRV_STOPPED) field_level <= 5'h00;
      else if (drive_source == esc_pkg::ESC_DRV_MOD_RAIL)
         field_level <= 5'(5'h10 - {1'b0, modulation_rail_level});
      else field_level <= 5'h10;
   end
endmodule // esc_driver_model

// [esc_edge_shaping_tb_top.sv]
// self-checking testbench for the edge shaping control block
// assumes the checker is bound in and inputs move 5 ns after each rising edge
`timescale 1ns/1ns
module esc_edge_shaping_tb_top;
   logic clk, rst, modulated, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   esc_pkg::esc_drive_e drive_source;
   logic [3:0] modulation_rail_level;
   logic clamp_switch_active, strong_sink_active, pattern_active;
   logic [4:0] field_level;
   int mismatches = 0;
   int cmp_count = 0;
   int n_fast, n_slow;

   esc_edge_shaping esc_edge_shaping_i (.clk(clk), .rst(rst), .modulated(modulated),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .drive_source(drive_source),
      .modulation_rail_level(modulation_rail_level), .clamp_switch_active(clamp_switch_active),
      .strong_sink_active(strong_sink_active), .pattern_active(pattern_active));
   esc_driver_model esc_driver_model_i (.clk(clk), .rst(rst), .drive_source(drive_source),
      .modulation_rail_level(modulation_rail_level), .field_level(field_level));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(); @(posedge clk); #5; endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d; tick(); reg_wr = 1'b0; tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_rd = 1'b1; reg_addr = a; tick(); reg_rd = 1'b0;
      chk("rdata", reg_rdata, exp); tick();
   endtask
   task automatic setpat(input logic [15:0] ov, input logic [15:0] un);
      wr(8'h34, ov[7:0]); wr(8'h35, ov[15:8]); wr(8'h36, un[7:0]); wr(8'h37, un[15:8]);
   endtask
   // one transition, then every cycle of the window and the first after it
   task automatic trans(input logic m, input logic [15:0] p);
      esc_pkg::esc_drive_e e;
      modulated = m;
      for (int k = 0; k < 15; k++) begin
         tick();
         e = m ? esc_pkg::ESC_DRV_MOD_RAIL : esc_pkg::ESC_DRV_DRIVER_RAIL;
         if (k < 14 && p[k] && p[15:14] != 2'h3) e = esc_pkg::esc_drive_e'(p[15:14]);
         chk("drive", drive_source, e);
         chk("active", pattern_active, 8'(k < 14));
      end
   endtask
   task automatic wait_lvl(input logic [3:0] v, output int n);
      n = 0;
      while (modulation_rail_level !== v && n < 400) begin tick(); n++; end
      chk("level", modulation_rail_level, v);
   endtask

   task automatic t_regs();
      rd(8'h28, 8'h00); rd(8'h37, 8'h00); rd(8'h00, 8'h00);
      wr(8'h34, 8'hA5); rd(8'h34, 8'hA5);
      wr(8'h2E, 8'h08); rd(8'h2E, 8'h08); wr(8'h2E, 8'h00);
   endtask
   task automatic t_patterns();
      logic [15:0] ov, un;
      for (int s = 0; s < 5; s++) begin
         ov = (s == 4) ? 16'h0000 : {2'(s), 14'h255B};
         un = (s == 4) ? 16'h0000 : {2'(s), 14'h1AC3};
         setpat(ov, un);
         trans(1'b1, un); trans(1'b0, ov);
      end
   endtask
   task automatic t_restart();
      wr(8'h38, 8'h01); setpat(16'h8003, 16'h4001);
      modulated = 1'b1; tick();
      trans(1'b0, 16'h8003);
   endtask
   task automatic t_shaping();
      wr(8'h28, 8'h94); wr(8'h2E, 8'h08); wr(8'h2F, 8'h1C); wr(8'h30, 8'h03);
      wr(8'h31, 8'h02); wr(8'h38, 8'hF0);
      modulated = 1'b1;
      for (int k = 0; k < 5; k++) begin
         tick(); chk("clamp", clamp_switch_active, 8'(k < 3));
         chk("sink", strong_sink_active, 8'h01);
      end
      modulated = 1'b0;
      for (int k = 0; k < 4; k++) begin
         tick(); chk("clamp", clamp_switch_active, 8'(k < 2));
      end
      chk("sink", strong_sink_active, 8'h00);
      rd(8'h3A, 8'h93);
   endtask
   task automatic t_filter(input logic [3:0] fs, output int n);
      int z;
      modulated = 1'b1;
      wr(8'h38, 8'h00); wait_lvl(4'h0, z);
      wr(8'h2F, {4'h2, fs}); wr(8'h38, 8'hF0); wait_lvl(4'hF, n);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #500_000;
      mismatches++;
      complete_run();
   end

   initial begin
      rst = 1'b1; modulated = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00;
      repeat (2) @(posedge clk);
      #5 rst = 1'b0;
      t_regs();
      t_patterns();
      t_restart();
      t_shaping();
      t_filter(4'h0, n_fast);
      t_filter(4'h8, n_slow);
      chk("slower", 8'(n_slow > n_fast), 8'h01);
      complete_run();
   end
endmodule // esc_edge_shaping_tb_top
